// ---- tb/test_scope_trigger_controller.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "tsc_regs.vh"
module test_scope_trigger_controller;
	// ==================================================
	// Signals
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata;
	wire         awready, wready, bvalid, arready, rvalid;
	wire  [31:0] rdata;
	wire  [1:0]  bresp, rresp;
	logic [2:0]  src, s, c;
	logic [1:0]  lvl;
	logic [15:0] lv;
	wire  [6:0]  cm, ch, cl;
	wire         sen, trig, done, rvld, div5, view;
	wire  [15:0] tpt, lmv;
	wire  [2:0]  cpl;
	integer      bad_count, n_checks, trig_cnt, i;
	tsc_trigger_ctrl #(.AUTO_TMO_CYC(32'd20), .FREQ_GATE(32'd100)) i_tsc_trigger_ctrl (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cmp_main(cm), .cmp_high(ch), .cmp_low(cl),
		.sample_en(sen), .trig_pulse_q(trig), .record_done_q(done),
		.record_valid_q(rvld), .trig_point_q(tpt), .path_coupling_q(cpl),
		.level_mv_q(lmv), .ext_div5_q(div5), .trigger_path_view_q(view));
	tsc_front_model i_tsc_front_model (.aclk(aclk), .src(src), .lvl(lvl),
		.cmp_main(cm), .cmp_high(ch), .cmp_low(cl), .sample_en(sen));
	// ==================================================
	// Clock, trigger counter, watchdog
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	always @(negedge aclk) if (trig === 1'b1) trig_cnt = trig_cnt + 1;
	initial begin
		#1500000;
		bad_count = bad_count + 1;
		close_out;
	end
	// ==================================================
	// Tasks and expectation functions
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Write holds each channel until taken, then waits for the response
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
		chk(r, er);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		r = 2'h3;
		d = 32'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		repeat (50) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
		chk(d, ed);
		chk(r, er);
	endtask
	// Trigger within a bound, checked at mid-cycle when outputs are settled
	task automatic trg(input logic [15:0] pt, input integer mw);
		integer n;
		n = 0;
		while (trig !== 1'b1 && n < mw) begin
			@(negedge aclk);
			n = n + 1;
		end
		chk(trig, 1'b1);
		chk(tpt, pt);
	endtask
	task automatic fin;
		integer n;
		n = 0;
		while (done !== 1'b1 && n < 4000) begin
			@(negedge aclk);
			n = n + 1;
		end
		chk(done, 1'b1);
		chk(rvld, 1'b1);
	endtask
	function automatic logic [31:0] cw(input logic [1:0] t, input logic sl, input logic m,
		input logic [2:0] cp, input logic [2:0] so);
		cw = {21'h0, so, 1'b0, cp, m, sl, t};
	endfunction
	// External clamps to 1600 mV, attenuated to 8000 mV, line forces zero
	function automatic logic [15:0] exp_lvl(input logic [2:0] so, input logic [15:0] l);
		integer v, lim;
		v = $signed(l);
		lim = (so == `TSC_SRC_EXT) ? 1600 : (so == `TSC_SRC_EXT5) ? 8000 : 40000;
		if (v > lim) v = lim;
		if (v < -lim) v = -lim;
		if (so == `TSC_SRC_LINE) v = 0;
		exp_lvl = v[15:0];
	endfunction
	task close_out;
		if (bad_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==================================================
	// Main sequence
	initial begin
		i = $urandom(32'hBBB09C55);
		{bad_count, n_checks, trig_cnt} = 0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
		src = 3'h1;
		lvl = 2'h0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, 2'h0);
		rd(8'h20, 32'h0, 2'h2);
		wr(8'h24, 32'hFFFF_FFFF, 2'h2);
		for (i = 0; i < 12; i++) begin
			s = (i % 4 == 0) ? 3'h0 : 3'(i % 4 + 3);
			c = 3'($urandom % 5);
			lv = (i < 2) ? 16'h8000 : 16'($urandom);
			wr(`TSC_OFS_LEVEL, {16'h0, lv}, 2'h0);
			wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b0, c, s), 2'h0);
			repeat (2) @(negedge aclk);
			chk(lmv, exp_lvl(s, lv));
			chk(cpl, (s == `TSC_SRC_LINE) ? 3'h0 : c);
			chk(div5, s == `TSC_SRC_EXT5);
			rd(`TSC_OFS_LVL_EFF, {16'h0, exp_lvl(s, lv)}, 2'h0);
		end
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b0, 3'h0, 3'h4), 2'h0);
		wr(`TSC_OFS_CTRL, cw(2'h1, 1'b0, 1'b0, 3'h0, 3'h6), 2'h0);
		rd(`TSC_OFS_CTRL, cw(2'h1, 1'b0, 1'b0, 3'h0, 3'h4), 2'h0);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b1, 3'h0, 3'h1), 2'h0);
		trig_cnt = 0;
		// Long enough for a record caught in auto mode to finish and re-arm
		repeat (5200) @(negedge aclk);
		chk(rvld, 1'b0);
		chk(trig_cnt, 0);
		lvl <= 2'h2;
		trg(16'd1250, 8);
		wr(`TSC_OFS_HPOS, 32'h0000_F830, 2'h0);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b1, 1'b1, 3'h0, 3'h1), 2'h0);
		lvl <= 2'h0;
		fin();
		lvl <= 2'h2;
		repeat (40) @(negedge aclk);
		chk(trig_cnt, 1);
		lvl <= 2'h0;
		trg(16'd0, 8);
		wr(`TSC_OFS_HPOS, 32'd100, 2'h0);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b1, `TSC_CPL_NOISE, 3'h1), 2'h0);
		lvl <= 2'h1;
		fin();
		repeat (2200) @(negedge aclk);
		chk(trig_cnt, 2);
		lvl <= 2'h2;
		trg(16'd1350, 8);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b1, `TSC_CPL_DC, 3'h1), 2'h0);
		lvl <= 2'h0;
		fin();
		lvl <= 2'h1;
		trg(16'd1350, 2500);
		// Dither rises every second cycle: half the 100-cycle gate
		rd(`TSC_OFS_FREQ, 32'h0000_0032, 2'h0);
		lvl <= 2'h0;
		fin();
		repeat (2200) @(negedge aclk);
		chk(trig_cnt, 4);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b1, 3'h0, 3'h1) | 32'h0003_0000, 2'h0);
		trg(16'd1350, 10);
		chk(view, 1'b1);
		wr(`TSC_OFS_CTRL, cw(2'h0, 1'b0, 1'b0, 3'h0, 3'h1), 2'h0);
		fin();
		trg(16'd1350, 2500);
		wr(`TSC_OFS_TBASE, {28'h0, `TSC_TB_FREE_IDX}, 2'h0);
		wr(`TSC_OFS_HPOS, 32'd2000, 2'h0);
		fin();
		trg(16'd2500, 4000);
		fin();
		close_out;
	end
endmodule // test_scope_trigger_controller
`default_nettype wire

// ---- tb/tsc_front_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// Far side: comparators on one scene source, sample strobe
module tsc_front_model (
	// Clock
	input  wire logic       aclk,
	// Scene: watched source, level 0 low, 1 dither, 2 high
	input  wire logic [2:0] src,
	input  wire logic [1:0] lvl,
	// Comparator outputs and sample strobe
	output logic      [6:0] cmp_main,
	output logic      [6:0] cmp_high,
	output logic      [6:0] cmp_low,
	output logic            sample_en
);
	logic [1:0] ph_q;
	integer     mv;
	initial begin
		ph_q = 2'h0;
		cmp_main = 7'h00;
		cmp_high = 7'h00;
		cmp_low = 7'h00;
		sample_en = 1'b0;
	end
	// Dither is 20 mV about the level, inside the 50 mV noise band
	// Other sources toggle every cycle so a wrong selection shows up
	always @(posedge aclk) begin
		ph_q <= ph_q + 2'h1;
		sample_en <= (ph_q != 2'h3);
		mv = (lvl == 2'h2) ? 100 : (lvl == 2'h0) ? -100 : (ph_q[0] ? 20 : -20);
		cmp_main <= ~cmp_main;
		cmp_high <= ~cmp_high;
		cmp_low <= ~cmp_low;
		cmp_main[src] <= (mv > 0);
		cmp_high[src] <= (mv > 50);
		cmp_low[src] <= (mv > -50);
	end
endmodule // tsc_front_model
`default_nettype wire

// ---- tb/tsc_trigger_ctrl_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// Port-level checks on trigger and record outputs
module tsc_trigger_ctrl_assertions (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Watched outputs
	input wire logic        trig_pulse_q,
	input wire logic        record_done_q,
	input wire logic        record_valid_q,
	input wire logic [15:0] trig_point_q,
	input wire logic [2:0]  path_coupling_q,
	input wire logic [15:0] level_mv_q,
	input wire logic        ext_div5_q
);
	logic armed_q;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Marks a record between its trigger and its end; done wins if both coincide
	always @(posedge aclk) begin
		if (!aresetn)
			armed_q <= 1'b0;
		else if (record_done_q)
			armed_q <= 1'b0;
		else if (trig_pulse_q)
			armed_q <= 1'b1;
	end
	pulse_one_cycle_a: assert property (trig_pulse_q |=> !trig_pulse_q)
		else $error("trigger pulse lasted more than one cycle");
	one_trig_rec_a: assert property (trig_pulse_q |-> !armed_q)
		else $error("second trigger inside one record");
	done_needs_trig_a: assert property (record_done_q |-> armed_q || trig_pulse_q)
		else $error("record ended without a trigger");
	done_one_cycle_a: assert property (record_done_q |=> !record_done_q)
		else $error("record done lasted more than one cycle");
	valid_on_done_a: assert property ($rose(record_valid_q) |-> record_done_q)
		else $error("record became valid without a finished record");
	point_in_rec_a: assert property (trig_pulse_q |-> trig_point_q <= 16'd2500)
		else $error("trigger point outside the record");
	div5_level_a: assert property (ext_div5_q |-> $signed(level_mv_q) <= 8000 &&
		$signed(level_mv_q) >= -8000) else $error("attenuated level out of range");
	cpl_code_a: assert property (path_coupling_q <= 3'h4)
		else $error("coupling code not defined");
endmodule // tsc_trigger_ctrl_assertions
bind tsc_trigger_ctrl tsc_trigger_ctrl_assertions i_tsc_trigger_ctrl_assertions (.aclk,
	.aresetn, .trig_pulse_q, .record_done_q, .record_valid_q, .trig_point_q,
	.path_coupling_q, .level_mv_q, .ext_div5_q);
`default_nettype wire

// ---- verilog/tsc_edge_det.v ----
`timescale 1ns/10ps
`default_nettype none
// ==================================================
// Comparator synchroniser, source select and crossing detect
module tsc_edge_det #(
	parameter W  = 7,
	parameter SW = 3
) (
	// Clock and reset
	input  wire          aclk,
	input  wire          aresetn,
	input  wire          ce,
	// Asynchronous comparator outputs, one bit per source
	input  wire [W-1:0]  cmp_main,
	input  wire [W-1:0]  cmp_high,
	input  wire [W-1:0]  cmp_low,
	// Selection
	input  wire [SW-1:0] sel,
	input  wire          hyst_en,
	input  wire          falling,
	// Result
	output reg           crossing_q
);
	reg [W-1:0] m1_q, m2_q, h1_q, h2_q, l1_q, l2_q;
	reg         level_q;
	reg         prev_q;
	reg         level_d;
	wire        sm;
	wire        sh;
	wire        sl;

	// ==================================================
	// Two-stage synchronisers; only stage two is read
	always @(posedge aclk) begin
		if (!aresetn) begin
			m1_q <= {W{1'b0}};
			m2_q <= {W{1'b0}};
			h1_q <= {W{1'b0}};
			h2_q <= {W{1'b0}};
			l1_q <= {W{1'b0}};
			l2_q <= {W{1'b0}};
		end else if (ce) begin
			m1_q <= cmp_main;
			m2_q <= m1_q;
			h1_q <= cmp_high;
			h2_q <= h1_q;
			l1_q <= cmp_low;
			l2_q <= l1_q;
		end
	end

	// Any channel may be picked, displayed or not
	assign sm = m2_q[sel];
	assign sh = h2_q[sel];
	assign sl = l2_q[sel];

	// Hysteresis holds the state between the two thresholds
	always @* begin
		level_d = sm;
		if (hyst_en) begin
			if (sh)
				level_d = 1'b1;
			else if (!sl)
				level_d = 1'b0;
			else
				level_d = level_q;
		end
	end

	// ==================================================
	// Crossing in the chosen direction, one-cycle pulse
	always @(posedge aclk) begin
		if (!aresetn) begin
			level_q    <= 1'b0;
			prev_q     <= 1'b0;
			crossing_q <= 1'b0;
		end else if (ce) begin
			level_q    <= level_d;
			prev_q     <= level_q;
			crossing_q <= falling ? (prev_q & ~level_q) : (~prev_q & level_q);
		end
	end
endmodule // tsc_edge_det
`default_nettype wire

// ---- verilog/tsc_regs.vh ----
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// ==================================================
// Register byte offsets (AXI4-Lite, one word each)
`define TSC_OFS_CTRL      8'h00
`define TSC_OFS_LEVEL     8'h04
`define TSC_OFS_HOLDOFF   8'h08
`define TSC_OFS_HPOS      8'h0C
`define TSC_OFS_TBASE     8'h10
`define TSC_OFS_STATUS    8'h14
`define TSC_OFS_FREQ      8'h18
`define TSC_OFS_LVL_EFF   8'h1C
// ==================================================
// Control register fields
`define TSC_F_TYPE        1:0
`define TSC_F_SLOPE       2
`define TSC_F_MODE        3
`define TSC_F_COUPLING    6:4
`define TSC_F_SOURCE      10:8
`define TSC_F_FORCE       16
`define TSC_F_VIEW        17
// ==================================================
// Reset values
`define TSC_RST_CTRL      32'h0000_0000
`define TSC_RST_LEVEL     16'h0000
`define TSC_RST_HOLDOFF   24'h00_0000
`define TSC_RST_HPOS      16'h0000
`define TSC_RST_TBASE     4'h0
// ==================================================
// Trigger types, modes, slopes
`define TSC_TYPE_EDGE     2'h0
`define TSC_TYPE_VIDEO    2'h1
`define TSC_TYPE_PULSE    2'h2
`define TSC_MODE_AUTO     1'b0
`define TSC_MODE_NORMAL   1'b1
`define TSC_SLOPE_RISE    1'b0
`define TSC_SLOPE_FALL    1'b1
// ==================================================
// Sources (index into comparator vectors)
`define TSC_SRC_CH1       3'h0
`define TSC_SRC_CH2       3'h1
`define TSC_SRC_CH3       3'h2
`define TSC_SRC_CH4       3'h3
`define TSC_SRC_EXT       3'h4
`define TSC_SRC_EXT5      3'h5
`define TSC_SRC_LINE      3'h6
`define TSC_NUM_SRC       7
// ==================================================
// Trigger path couplings
`define TSC_CPL_DC        3'h0
`define TSC_CPL_AC        3'h1
`define TSC_CPL_NOISE     3'h2
`define TSC_CPL_HFBLK     3'h3
`define TSC_CPL_LFBLK     3'h4
// ==================================================
// Level limits in millivolts, timing
`define TSC_EXT_LIM_MV    16'd1600
`define TSC_EXT5_LIM_MV   16'd8000
`define TSC_LINE_LVL_MV   16'h0000
`define TSC_CLK_MHZ       40
`define TSC_AUTO_TMO_US   1000
`define TSC_FREQ_GATE_MS  1000
`define TSC_TB_FREE_IDX   4'h9
`define TSC_REC_LEN       2500
`endif

// ---- verilog/tsc_trigger_ctrl.v ----
// Contract
// - Edge, video and pulse-width types; edge after reset; each its own options; only the edge type qualifies a trigger here
// - Edge type triggers when source crosses the threshold in chosen direction
// - Slope picks rising or falling crossings
// - Source is a channel, external, external/5 or power line; ch3/4 four-channel only
// - A channel triggers whether or not it is displayed
// - External source not displayed; level limited to +1.6 V..-1.6 V
// - External/5 scales by five; level limited to +8 V..-8 V
// - Power line forces DC coupling and zero level, triggers from line signal
// - Power line source only selectable in edge type
// - Auto mode forces a trigger after a timebase-dependent timeout
// - Auto at 100 ms/div or slower free-runs untriggered
// - Normal mode updates the record only on a valid trigger
// - Normal mode shows no record until first trigger after entry
// - Counts triggerable events and reports trigger frequency
// - Coupling picks AC, DC, noise, high-freq or low-freq reject
// - Noise reject adds hysteresis to the comparison
// - Coupling acts on the trigger path only
// - Trigger point at record centre by default; position shifts it
// - Triggers ignored during programmable holdoff after each trigger
// - Force request completes acquisition without a trigger
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "tsc_regs.vh"
module tsc_trigger_ctrl #(
	parameter        NUM_CH       = 4,
	parameter        REC_LEN      = `TSC_REC_LEN,
	parameter [31:0] AUTO_TMO_CYC = `TSC_AUTO_TMO_US * `TSC_CLK_MHZ,
	parameter [31:0] FREQ_GATE    = `TSC_FREQ_GATE_MS * `TSC_CLK_MHZ * 1000
) (
	// Clock, reset, enable
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Comparator pins, bit index is the source code
	input  wire [6:0]  cmp_main,
	input  wire [6:0]  cmp_high,
	input  wire [6:0]  cmp_low,
	// Acquisition side
	input  wire        sample_en,
	output reg         trig_pulse_q,
	output reg         record_done_q,
	output reg         record_valid_q,
	output reg  [15:0] trig_point_q,
	// Trigger path front end
	output reg  [2:0]  path_coupling_q,
	output reg  [15:0] level_mv_q,
	output reg         ext_div5_q,
	output reg         trigger_path_view_q
);
	localparam [1:0]  S_PRE  = 2'h0;
	localparam [1:0]  S_WAIT = 2'h1;
	localparam [1:0]  S_POST = 2'h2;
	localparam [15:0] HALF   = REC_LEN / 2;
	localparam [15:0] RLEN   = REC_LEN;

	// ==================================================
	// Decoding helpers
	// Power line only in edge type; ch3/ch4 only on four-channel builds
	function src_ok;
		input [2:0] s;
		input [1:0] t;
		begin
			src_ok = 1'b1;
			if (s > `TSC_SRC_LINE)
				src_ok = 1'b0;
			else if (s == `TSC_SRC_LINE && t != `TSC_TYPE_EDGE)
				src_ok = 1'b0;
			else if ((s == `TSC_SRC_CH3 || s == `TSC_SRC_CH4) && NUM_CH < 4)
				src_ok = 1'b0;
		end
	endfunction

	function [15:0] clamp;
		input [15:0] v;
		input [15:0] lim;
		begin
			if ($signed(v) > $signed(lim))
				clamp = lim;
			else if ($signed(v) < -$signed(lim))
				clamp = 16'h0000 - lim;
			else
				clamp = v;
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// ==================================================
	// State
	reg [1:0]  type_q;
	reg        slope_q, mode_q, view_q;
	reg [2:0]  coup_q, src_q;
	reg [15:0] level_q, hpos_q;
	reg [23:0] hold_len_q, hold_q;
	reg [3:0]  tb_q;
	reg        force_q, valid_seen_q, stale_q;
	reg [1:0]  state_q;
	reg [15:0] cnt_q;
	reg [31:0] tmo_q, gate_q, ev_q, freq_q;
	reg [7:0]  aw_q;
	reg [31:0] wd_q;
	reg [3:0]  ws_q;
	reg        have_aw_q, have_w_q;
	reg [15:0] lvl_eff;
	reg [2:0]  cpl_eff;
	reg [31:0] rd;
	reg        rd_ok;
	reg [31:0] cw;
	reg [2:0]  new_src;
	reg [15:0] pre_tgt;
	wire       crossing;
	wire       wr_go = have_aw_q & have_w_q & ~s_axi_bvalid;
	wire       wr_ctrl = wr_go & (aw_q == `TSC_OFS_CTRL);
	wire       free_run;
	wire       valid_trig;
	wire       auto_exp;
	wire       fire;
	wire       enter_normal;
	// Byte-merged images of the writable registers, cut to width where stored
	wire [31:0] lvl_m  = merge({16'h0, level_q}, wd_q, ws_q);
	wire [31:0] hold_m = merge({8'h0, hold_len_q}, wd_q, ws_q);
	wire [31:0] hpos_m = merge({16'h0, hpos_q}, wd_q, ws_q);
	wire [31:0] tb_m   = merge({28'h0, tb_q}, wd_q, ws_q);
	// Last sample of the posttrigger part
	wire       last_smp = (state_q == S_POST) & sample_en & (cnt_q >= RLEN - 16'h1);

	// ==================================================
	// Trigger path source selection and crossing detect
	tsc_edge_det #(
		.W  (`TSC_NUM_SRC),
		.SW (3)
	) u_edge (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.cmp_main   (cmp_main),
		.cmp_high   (cmp_high),
		.cmp_low    (cmp_low),
		.sel        (src_q),
		.hyst_en    (cpl_eff == `TSC_CPL_NOISE),
		.falling    (slope_q == `TSC_SLOPE_FALL),
		.crossing_q (crossing)
	);

	// Effective level and coupling; line source overrides both
	always @* begin
		cpl_eff = coup_q;
		case (src_q)
			`TSC_SRC_EXT:  lvl_eff = clamp(level_q, `TSC_EXT_LIM_MV);
			`TSC_SRC_EXT5: lvl_eff = clamp(level_q, `TSC_EXT5_LIM_MV);
			`TSC_SRC_LINE: begin
				lvl_eff = `TSC_LINE_LVL_MV;
				cpl_eff = `TSC_CPL_DC;
			end
			default:       lvl_eff = level_q;
		endcase
	end

	// New source on a control write; an illegal pick keeps the old one if still legal
	always @* begin
		cw = merge({14'h0, view_q, 6'h00, src_q, 1'b0, coup_q, mode_q, slope_q, type_q},
		           wd_q, ws_q);
		if (src_ok(cw[`TSC_F_SOURCE], cw[`TSC_F_TYPE]))
			new_src = cw[`TSC_F_SOURCE];
		else if (src_ok(src_q, cw[`TSC_F_TYPE]))
			new_src = src_q;
		else
			new_src = `TSC_SRC_CH1;
	end

	// ==================================================
	// AXI4-Lite write channel; address and data taken in either order
	assign s_axi_awready = ~have_aw_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~have_w_q & ~s_axi_bvalid;
	assign enter_normal  = wr_ctrl & ~mode_q & cw[`TSC_F_MODE];

	always @(posedge aclk) begin
		if (!aresetn) begin
			have_aw_q    <= 1'b0;
			have_w_q     <= 1'b0;
			aw_q         <= 8'h00;
			wd_q         <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			type_q       <= `TSC_TYPE_EDGE;
			slope_q      <= `TSC_SLOPE_RISE;
			mode_q       <= `TSC_MODE_AUTO;
			coup_q       <= `TSC_CPL_DC;
			src_q        <= `TSC_SRC_CH1;
			view_q       <= 1'b0;
			level_q      <= `TSC_RST_LEVEL;
			hold_len_q   <= `TSC_RST_HOLDOFF;
			hpos_q       <= `TSC_RST_HPOS;
			tb_q         <= `TSC_RST_TBASE;
			force_q      <= 1'b0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q      <= s_axi_awaddr;
				have_aw_q <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_q     <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
				have_w_q <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			// A fired trigger consumes the force; a new request in that cycle wins
			if (fire)
				force_q <= 1'b0;
			if (wr_go) begin
				have_aw_q    <= 1'b0;
				have_w_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case (aw_q)
					`TSC_OFS_CTRL: begin
						type_q  <= (cw[`TSC_F_TYPE] > `TSC_TYPE_PULSE) ?
						           type_q : cw[`TSC_F_TYPE];
						slope_q <= cw[`TSC_F_SLOPE];
						mode_q  <= cw[`TSC_F_MODE];
						coup_q  <= (cw[`TSC_F_COUPLING] > `TSC_CPL_LFBLK) ?
						           coup_q : cw[`TSC_F_COUPLING];
						src_q   <= new_src;
						view_q  <= cw[`TSC_F_VIEW];
						if (cw[`TSC_F_FORCE])
							force_q <= 1'b1;
					end
					`TSC_OFS_LEVEL:   level_q    <= lvl_m[15:0];
					`TSC_OFS_HOLDOFF: hold_len_q <= hold_m[23:0];
					`TSC_OFS_HPOS:    hpos_q     <= hpos_m[15:0];
					`TSC_OFS_TBASE:   tb_q       <= tb_m[3:0];
					`TSC_OFS_STATUS, `TSC_OFS_FREQ, `TSC_OFS_LVL_EFF: ;
					default:          s_axi_bresp <= 2'h2;
				endcase
			end
		end
	end

	// ==================================================
	// AXI4-Lite read channel, answer one cycle after the address
	assign s_axi_arready = ~s_axi_rvalid;

	always @* begin
		rd    = 32'h0000_0000;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			`TSC_OFS_CTRL:    rd = {14'h0, view_q, force_q, 5'h00, src_q, 1'b0,
			                        coup_q, mode_q, slope_q, type_q};
			`TSC_OFS_LEVEL:   rd = {16'h0, level_q};
			`TSC_OFS_HOLDOFF: rd = {8'h0, hold_len_q};
			`TSC_OFS_HPOS:    rd = {16'h0, hpos_q};
			`TSC_OFS_TBASE:   rd = {28'h0, tb_q};
			`TSC_OFS_STATUS:  rd = {25'h0, valid_seen_q, free_run, |hold_q,
			                        record_valid_q, state_q, 1'b0};
			`TSC_OFS_FREQ:    rd = freq_q;
			`TSC_OFS_LVL_EFF: rd = {16'h0, lvl_eff};
			default:          rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd;
				s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==================================================
	// Trigger qualification
	// Video and pulse qualifiers are outside this block, so only edge qualifies
	assign valid_trig = crossing & (type_q == `TSC_TYPE_EDGE) & (hold_q == 24'h0);
	assign free_run   = (mode_q == `TSC_MODE_AUTO) & (tb_q >= `TSC_TB_FREE_IDX);
	assign auto_exp   = (mode_q == `TSC_MODE_AUTO) & (tmo_q >= (AUTO_TMO_CYC << tb_q));
	assign fire       = (state_q == S_WAIT) & (valid_trig | force_q | auto_exp | free_run);

	// Pretrigger amount: half a record, moved by the signed position, kept in range
	always @* begin
		if ($signed({1'b0, HALF}) + $signed(hpos_q) < 0)
			pre_tgt = 16'h0000;
		else if ($signed({1'b0, HALF}) + $signed(hpos_q) > $signed({1'b0, RLEN}))
			pre_tgt = RLEN;
		else
			pre_tgt = HALF + hpos_q;
	end

	// ==================================================
	// Record sequencer: pretrigger, wait, posttrigger
	always @(posedge aclk) begin
		if (!aresetn) begin
			state_q        <= S_PRE;
			cnt_q          <= 16'h0000;
			tmo_q          <= 32'h0000_0000;
			hold_q         <= 24'h00_0000;
			trig_pulse_q   <= 1'b0;
			record_done_q  <= 1'b0;
			record_valid_q <= 1'b0;
			valid_seen_q   <= 1'b0;
			stale_q        <= 1'b0;
			trig_point_q   <= 16'h0000;
		end else if (ce) begin
			trig_pulse_q  <= 1'b0;
			record_done_q <= 1'b0;
			if (hold_q != 24'h0)
				hold_q <= hold_q - 24'h1;
			// Entering normal hides records until a fresh one completes
			if (enter_normal)
				record_valid_q <= 1'b0;
			// A record caught before normal was entered finishes but is never shown
			if (enter_normal & (fire | ((state_q == S_POST) & ~last_smp)))
				stale_q <= 1'b1;
			case (state_q)
				S_PRE: begin
					tmo_q <= 32'h0000_0000;
					if (cnt_q >= pre_tgt)
						state_q <= S_WAIT;
					else if (sample_en)
						cnt_q <= cnt_q + 16'h1;
				end
				S_WAIT: begin
					if (mode_q == `TSC_MODE_AUTO)
						tmo_q <= tmo_q + 32'h1;
					if (fire) begin
						trig_pulse_q <= 1'b1;
						trig_point_q <= cnt_q;
						valid_seen_q <= valid_trig;
						hold_q       <= hold_len_q;
						state_q      <= S_POST;
					end
				end
				S_POST: begin
					if (sample_en) begin
						if (cnt_q >= RLEN - 16'h1) begin
							cnt_q          <= 16'h0000;
							record_done_q  <= 1'b1;
							record_valid_q <= ~stale_q & ~enter_normal;
							stale_q        <= 1'b0;
							state_q        <= S_PRE;
						end else begin
							cnt_q <= cnt_q + 16'h1;
						end
					end
				end
				default: state_q <= S_PRE;
			endcase
		end
	end

	// ==================================================
	// Trigger frequency: triggerable events per one-second gate
	always @(posedge aclk) begin
		if (!aresetn) begin
			gate_q <= 32'h0000_0000;
			ev_q   <= 32'h0000_0000;
			freq_q <= 32'h0000_0000;
		end else if (ce) begin
			if (gate_q >= FREQ_GATE - 32'h1) begin
				gate_q <= 32'h0000_0000;
				freq_q <= ev_q + {31'h0, crossing};
				ev_q   <= 32'h0000_0000;
			end else begin
				gate_q <= gate_q + 32'h1;
				ev_q   <= ev_q + {31'h0, crossing};
			end
		end
	end

	// ==================================================
	// Front-end settings; coupling goes to the trigger path only
	always @(posedge aclk) begin
		if (!aresetn) begin
			path_coupling_q     <= `TSC_CPL_DC;
			level_mv_q          <= `TSC_RST_LEVEL;
			ext_div5_q          <= 1'b0;
			trigger_path_view_q <= 1'b0;
		end else if (ce) begin
			path_coupling_q     <= cpl_eff;
			level_mv_q          <= lvl_eff;
			ext_div5_q          <= (src_q == `TSC_SRC_EXT5);
			trigger_path_view_q <= view_q;
		end
	end
endmodule // tsc_trigger_ctrl
`default_nettype wire
